// ==== adcsp_pkg.sv ====
// Package with shared constants and types for the converter serial port block.
package adcsp_pkg;
  // ==========================================================================
  // Frame layout.
  localparam int unsigned FRAME_BITS     = 16;
  localparam int unsigned CMD_BITS       = 4;
  localparam int unsigned DATA_BITS      = 12;
  localparam logic [4:0]  EDGE_LIMIT     = 5'h10;
  localparam logic [4:0]  CHAN_READY_CNT = 5'h04;
  // ==========================================================================
  // Command and mode codes.
  localparam logic [3:0]  CMD_CFG_WRITE  = 4'hA;
  localparam logic [1:0]  MODE_ONE_SHOT  = 2'h0;
  localparam logic [1:0]  MODE_SELECT    = 2'h1;
  localparam int unsigned CMD_LIMIT_FOUR = 12;
  // ==========================================================================
  // Conversion timing in converter clocks.
  localparam logic [4:0]  CONV_CYCLES    = 5'h0C;
  // Host link clock half period in pclk cycles, less one (160 ns period at 20 ns).
  localparam int unsigned LINK_PERIOD_NS = 160;
  localparam int unsigned PCLK_NS        = 20;
  localparam logic [2:0]  SCLK_HALF      = 3'((LINK_PERIOD_NS / PCLK_NS) / 2 - 1);
  // ==========================================================================
  // Host APB register map.
  localparam logic [11:0] REG_CTRL       = 12'h000;
  localparam logic [11:0] REG_TXDATA     = 12'h004;
  localparam logic [11:0] REG_RXDATA     = 12'h008;
  localparam logic [11:0] REG_STATUS     = 12'h00C;
  localparam int unsigned CTRL_START     = 0;
  localparam int unsigned CTRL_USE_FS    = 1;
  localparam int unsigned CTRL_CONVERSION_START_PIN    = 2;
  localparam int unsigned CTRL_POWER_DOWN_PIN_N    = 3;
  localparam int unsigned ST_BUSY        = 0;
  localparam int unsigned ST_FLAG        = 1;
  typedef enum {ADCSP_IDLE, ADCSP_SETUP, ADCSP_HIGH, ADCSP_LOW, ADCSP_END} adcsp_host_state_t;
endpackage : adcsp_pkg

// ==== adcsp_if.sv ====
// Interface joining the converter serial port and its host.
`timescale 1ns/100ps
`default_nettype none
interface adcsp_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic frame_sync_n;
  logic conversion_start_pin_n;
  logic power_down_pin_n;
  logic sdo_o;
  logic sdo_oe;
  logic flag_n;
  // Resolved serial output as seen on the wire; floats high when undriven.
  wire  sdo = sdo_oe ? sdo_o : 1'b1;
  // ==========================================================================
  modport dev  (input cs_n, sclk, sdi, frame_sync_n, conversion_start_pin_n,
                power_down_pin_n, output sdo_o, sdo_oe, flag_n);
  modport host (output cs_n, sclk, sdi, frame_sync_n, conversion_start_pin_n,
                power_down_pin_n, input sdo, flag_n);
endinterface : adcsp_if
`default_nettype wire

// ==== adcsp_dev.sv ====
// Device end: serial port, conversion control and flag output of the converter.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// RULE1: Chip select fall clears counter, enables I/O.
// RULE2: Input stops after 16 edges or select rise.
// RULE3: Host moves chip select only while SCLK low.
// RULE4: Start pin low time sets sampling, select high.
// RULE5: Mode 01 defers sampling until select rises.
// RULE6: Start pin rise ends sampling, begins conversion.
// RULE7: End flag low from sampling end to done.
// RULE8: End-of-conversion flag only in mode 00.
// RULE9: Interrupt flag low when ready, next fall clears.
// RULE10: Frame sync low after select keeps input off.
// RULE11: Frame sync fall clears counter, enables input.
// RULE12: Power-down pin stops analog; restart on activity.
// RULE13: SCLK shifts input; optional conversion clock.
// RULE14: Host keeps SCLK low when idle.
// RULE15: MSB first; leading four bits form command.
// RULE16: Configuration writes carry twelve more bits.
// RULE17: Plain timing captures input on rising SCLK.
// RULE18: Frame sync timing captures on falling SCLK.
// RULE19: Host should use start pin for slow sources.
// RULE20: Plain timing changes output on falling SCLK.
// RULE21: Frame sync timing changes output on rising SCLK.
// RULE22: Output floats after sixteenth bit.
// RULE23: Frame sync level at select fall picks timing.
module adcsp_dev
  import adcsp_pkg::*;
#(
  parameter bit FOUR_CHANNEL = 1'b0
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Serial link.
  adcsp_if.dev             link,
  // User side.
  input  wire logic [11:0] sample_value,
  output logic      [11:0] cfg_data,
  output logic      [3:0]  last_cmd,
  output logic             cmd_valid,
  output logic             sampling,
  output logic             converting,
  output logic             analog_on
);
  // ==========================================================================
  // Pin synchronisers; logic reads stage two, and prev_r behind it for edges.
  logic [4:0] s1_r;
  logic [4:0] s2_r;
  logic [4:0] prev_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Idle pin levels, SCLK low, so release from reset makes no false edge.
      s1_r   <= 5'h1D;
      s2_r   <= 5'h1D;
      prev_r <= 5'h1D;
    end else begin
      s1_r   <= {link.power_down_pin_n, link.conversion_start_pin_n, link.frame_sync_n,
                 link.sclk, link.cs_n};
      s2_r   <= s1_r;
      prev_r <= s2_r;
    end
  end
  wire cs_q    = s2_r[0];
  wire sclk_q  = s2_r[1];
  wire fs_q    = s2_r[2];
  wire cst_q   = s2_r[3];
  wire power_down_pin_nq = s2_r[4];
  wire cs_fall   = prev_r[0] & ~cs_q;
  wire cs_rise   = ~prev_r[0] & cs_q;
  wire sclk_rise = ~prev_r[1] & sclk_q;
  wire sclk_fall = prev_r[1] & ~sclk_q;
  wire fs_fall   = prev_r[2] & ~fs_q;
  wire cst_fall  = prev_r[3] & ~cst_q;
  wire cst_rise  = ~prev_r[3] & cst_q;
  wire sdi_q;
  logic sdi1_r;
  logic sdi2_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdi1_r <= 1'b0;
      sdi2_r <= 1'b0;
    end else begin
      sdi1_r <= link.sdi;
      sdi2_r <= sdi1_r;
    end
  end
  assign sdi_q = sdi2_r;
  // ==========================================================================
  // Frame control state.
  logic        fs_mode_r;
  logic        in_en_r;
  logic [4:0]  edge_cnt_r;
  logic [15:0] shift_r;
  logic [15:0] out_r;
  logic        sdo_oe_r;
  logic [4:0]  out_cnt_r;
  logic [1:0]  conv_mode_r;
  logic        flag_int_r;
  // Timing choice at chip select fall, frame sync level sampled then.
  wire fs_mode_now = cs_fall ? ~fs_q : fs_mode_r;                // [RULE23]
  wire start_frame = cs_fall | (fs_fall & ~cs_q);                // [RULE1] [RULE11]
  // A frame sync falling together with select is an active one and opens input.
  wire frame_on    = fs_fall | (cs_fall ? fs_q : in_en_r);       // [RULE10]
  // Capture edge depends on the timing chosen for the frame.
  wire cap_edge    = fs_mode_r ? sclk_fall : sclk_rise;          // [RULE17] [RULE18]
  wire out_edge    = fs_mode_r ? sclk_rise : sclk_fall;          // [RULE20] [RULE21]
  wire last_edge   = in_en_r & cap_edge & (edge_cnt_r == EDGE_LIMIT - 5'h01);
  wire [3:0] cmd_w = shift_r[14:11];
  wire cmd_ok      = !FOUR_CHANNEL || (int'(cmd_w) < CMD_LIMIT_FOUR); // [RULE15]
  // Input shifter and edge counter, MSB first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_mode_r  <= 1'b0;
      in_en_r    <= 1'b0;
      edge_cnt_r <= 5'h00;
      shift_r    <= 16'h0000;
      cmd_valid  <= 1'b0;
      last_cmd   <= 4'h0;
      cfg_data   <= 12'h000;
      conv_mode_r <= MODE_ONE_SHOT;
    end else begin
      fs_mode_r <= fs_mode_now;
      cmd_valid <= 1'b0;
      if (cs_rise) begin
        in_en_r <= 1'b0;                                          // [RULE2]
      end else if (start_frame) begin
        edge_cnt_r <= 5'h00;                                      // [RULE1] [RULE11]
        in_en_r    <= frame_on;
      end else if (in_en_r && cap_edge) begin
        shift_r    <= {shift_r[14:0], sdi_q};                     // [RULE13] [RULE15]
        edge_cnt_r <= edge_cnt_r + 5'h01;
        if (last_edge) begin
          in_en_r   <= 1'b0;                                      // [RULE2]
          last_cmd  <= shift_r[14:11];
          cmd_valid <= cmd_ok;
          if (shift_r[14:11] == CMD_CFG_WRITE) begin
            cfg_data    <= {shift_r[10:0], sdi_q};                // [RULE16]
            conv_mode_r <= shift_r[3:2];
          end
        end
      end
    end
  end
  // ==========================================================================
  // Output shifter: MSB presented at frame start, floats after bit sixteen.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r     <= 16'h0000;
      sdo_oe_r  <= 1'b0;
      out_cnt_r <= 5'h00;
    end else if (cs_q) begin
      sdo_oe_r  <= 1'b0;
    end else if (start_frame && frame_on) begin
      out_r     <= {sample_value, 4'h0};
      sdo_oe_r  <= 1'b1;                                          // [RULE1]
      out_cnt_r <= 5'h01;
    end else if (sdo_oe_r && out_edge) begin
      if (out_cnt_r == EDGE_LIMIT) begin
        sdo_oe_r <= 1'b0;                                         // [RULE22]
      end else begin
        out_r     <= {out_r[14:0], 1'b0};
        out_cnt_r <= out_cnt_r + 5'h01;
      end
    end
  end
  // ==========================================================================
  // Sampling and conversion. SCLK paces the conversion while selected and pclk while deselected, so no oscillator model is needed.
  logic        arm_r;
  logic [4:0]  conv_cnt_r;
  wire cst_arm  = cst_fall & (cs_q | (conv_mode_r == MODE_SELECT)); // [RULE5]
  wire samp_go  = cs_q & (arm_r | (cst_fall & cs_q));              // [RULE4] [RULE5]
  wire conv_go  = sampling & cst_rise & cs_q;                      // [RULE6]
  wire conv_end = converting & (conv_cnt_r == CONV_CYCLES);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_r      <= 1'b0;
      sampling   <= 1'b0;
      converting <= 1'b0;
      conv_cnt_r <= 5'h00;
      analog_on  <= 1'b1;
      flag_int_r <= 1'b1;
    end else begin
      if (!power_down_pin_nq) begin
        analog_on <= 1'b0;                                        // [RULE12]
        arm_r     <= 1'b0;
        sampling  <= 1'b0;
        converting <= 1'b0;
      end else begin
        if (!analog_on && (cs_fall || fs_fall || cst_fall)) begin
          analog_on <= 1'b1;                                      // [RULE12]
        end
        if (cst_arm && !cs_q) arm_r <= 1'b1;
        else if (samp_go) arm_r <= 1'b0;
        if (samp_go && cst_q == 1'b0) sampling <= 1'b1;
        if (conv_go) begin
          sampling   <= 1'b0;
          converting <= 1'b1;
          conv_cnt_r <= 5'h00;
        end else if (converting && (sclk_rise || cs_q)) begin
          conv_cnt_r <= conv_cnt_r + 5'h01;                       // [RULE13]
        end
        if (conv_end) converting <= 1'b0;
      end
      // Flag: set on completion wins over clear by the next frame.
      if (conv_end) flag_int_r <= 1'b0;                           // [RULE9]
      else if (start_frame) flag_int_r <= 1'b1;                   // [RULE9]
    end
  end
  // End-of-conversion form applies only in one-shot mode.
  wire eoc_mode = (conv_mode_r == MODE_ONE_SHOT);                 // [RULE8]
  logic flag_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flag_r <= 1'b1;
    else flag_r <= eoc_mode ? ~(converting & ~conv_end) : flag_int_r; // [RULE7]
  end
  assign link.sdo_o  = out_r[15];
  assign link.sdo_oe = sdo_oe_r;
  assign link.flag_n = flag_r;
endmodule : adcsp_dev
`default_nettype wire

// ==== adcsp_host.sv ====
// Host end: APB-controlled master that drives the converter serial port.
`timescale 1ns/100ps
`default_nettype none
module adcsp_host
  import adcsp_pkg::*;
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial link.
  adcsp_if.host            link
);
  // ==========================================================================
  // Register decode; unmapped addresses answer with an error.
  wire acc     = psel & penable & ~pready;
  wire done    = psel & penable & pready;
  wire hit_ctl = paddr == REG_CTRL;
  wire hit_tx  = paddr == REG_TXDATA;
  wire hit_rx  = paddr == REG_RXDATA;
  wire hit_st  = paddr == REG_STATUS;
  wire mapped  = hit_ctl | hit_tx | hit_rx | hit_st;
  logic [3:0]  ctrl_r;
  logic [15:0] tx_r;
  logic [15:0] rx_r;
  logic        flag1_r;
  logic        flag2_r;
  adcsp_host_state_t state_r;
  logic [2:0]  div_r;
  logic [4:0]  bit_r;
  logic [15:0] sh_r;
  logic        cs_n_r;
  logic        sclk_r;
  logic        fs_r;
  logic        sdo1_r;
  logic        sdo2_r;
  wire  busy   = state_r != ADCSP_IDLE;
  wire  tick   = div_r == SCLK_HALF;
  wire  go     = done & pwrite & hit_ctl & pwdata[CTRL_START] & ~busy;
  wire [31:0] rd_w = hit_ctl ? {28'h0, ctrl_r} :
                     hit_tx  ? {16'h0, tx_r} :
                     hit_rx  ? {16'h0, rx_r} :
                     {30'h0, ~flag2_r, busy};
  // APB answer one cycle after the access phase begins; writes land at the ready edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      ctrl_r  <= 4'hC;
      tx_r    <= 16'h0;
    end else begin
      pready  <= acc;
      pslverr <= acc & ~mapped;
      if (acc && !pwrite) prdata <= rd_w;
      if (done && pwrite && hit_ctl) ctrl_r <= {pwdata[3:1], 1'b0};
      if (done && pwrite && hit_tx)  tx_r   <= pwdata[15:0];
    end
  end
  // ==========================================================================
  // Synchronisers for the device outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdo1_r  <= 1'b1;
      sdo2_r  <= 1'b1;
      flag1_r <= 1'b1;
      flag2_r <= 1'b1;
    end else begin
      sdo1_r  <= link.sdo;
      sdo2_r  <= sdo1_r;
      flag1_r <= link.flag_n;
      flag2_r <= flag1_r;
    end
  end
  // ==========================================================================
  // Frame engine: SCLK idles low, chip select moves only with SCLK low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ADCSP_IDLE;
      div_r   <= 3'h0;
      bit_r   <= 5'h00;
      sh_r    <= 16'h0;
      rx_r    <= 16'h0;
      cs_n_r  <= 1'b1;
      sclk_r  <= 1'b0;
      fs_r    <= 1'b1;
    end else begin
      div_r <= (busy && !tick) ? div_r + 3'h1 : 3'h0;
      case (state_r)
        ADCSP_IDLE: if (go) begin                                   // [RULE3] [RULE14]
          cs_n_r  <= 1'b0;
          fs_r    <= ~ctrl_r[CTRL_USE_FS];
          sh_r    <= tx_r;                                          // [RULE17] [RULE18]
          bit_r   <= 5'h00;
          state_r <= ADCSP_SETUP;
        end
        ADCSP_SETUP: if (tick) begin
          fs_r    <= 1'b1;
          sclk_r  <= ~ctrl_r[CTRL_USE_FS];
          state_r <= ctrl_r[CTRL_USE_FS] ? ADCSP_LOW : ADCSP_HIGH;
        end
        ADCSP_HIGH: if (tick) begin
          sclk_r <= 1'b0;
          if (ctrl_r[CTRL_USE_FS]) begin
            rx_r  <= {rx_r[14:0], sdo2_r};
            bit_r <= bit_r + 5'h01;
          end
          state_r <= (bit_r == EDGE_LIMIT - 5'h01 && ctrl_r[CTRL_USE_FS]) ?
                     ADCSP_END : ADCSP_LOW;
        end
        ADCSP_LOW: if (tick) begin
          if (!ctrl_r[CTRL_USE_FS]) begin
            if (bit_r == EDGE_LIMIT - 5'h01) begin
              state_r <= ADCSP_END;
            end else begin
              sclk_r  <= 1'b1;
              state_r <= ADCSP_HIGH;
            end
            sh_r  <= {sh_r[14:0], 1'b0};
            bit_r <= bit_r + 5'h01;
          end else begin
            sclk_r  <= 1'b1;
            state_r <= ADCSP_HIGH;
            // Next bit leaves on the rising edge, clear of the falling capture.
            if (bit_r != 5'h00) sh_r <= {sh_r[14:0], 1'b0};           // [RULE18]
          end
        end
        ADCSP_END: if (tick) begin
          cs_n_r  <= 1'b1;                                          // [RULE3]
          state_r <= ADCSP_IDLE;
        end
        default: state_r <= ADCSP_IDLE;
      endcase
      // Plain timing samples device data as it lowers SCLK, before the device moves it on that falling edge.
      if (!ctrl_r[CTRL_USE_FS] && state_r == ADCSP_HIGH && tick) begin
        rx_r <= {rx_r[14:0], sdo2_r};
      end
    end
  end
  assign link.cs_n                   = cs_n_r;
  assign link.sclk                   = sclk_r;
  assign link.sdi                    = sh_r[15];
  assign link.frame_sync_n           = fs_r;
  assign link.conversion_start_pin_n = ctrl_r[CTRL_CONVERSION_START_PIN];       // [RULE19]
  assign link.power_down_pin_n       = ctrl_r[CTRL_POWER_DOWN_PIN_N];
endmodule : adcsp_host
`default_nettype wire

// ==== adcsp_properties.sv ====
// Concurrent checks on the serial link between host and converter ends.
`timescale 1ns/100ps
`default_nettype none
module adcsp_properties (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Link signals.
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic frame_sync_n,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic flag_n
);
  // ==========================================================================
  // Frame timing choice and count of rising SCLK edges in the frame.
  // The choice also latches a frame sync lowered later in the frame, though the host lowers it together with select.
  logic       fs_mode_r;
  logic [4:0] rise_cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_mode_r  <= 1'b0;
      rise_cnt_r <= 5'h00;
    end else if ($fell(cs_n)) begin
      fs_mode_r  <= !frame_sync_n;
      rise_cnt_r <= 5'h00;
    end else if (!cs_n && $rose(sclk)) begin
      rise_cnt_r <= rise_cnt_r + 5'h01;
    end else if (!cs_n && !frame_sync_n) begin
      fs_mode_r  <= 1'b1;
    end
  end
  // ==========================================================================
  // Properties, all in the pclk domain.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_sdo_float_idle: assert property (cs_n [*5] |-> !sdo_oe)
    else $error("serial output driven while deselected");
  chk_sdo_plain_on: assert property ($fell(cs_n) && frame_sync_n |-> ##[1:6] sdo_oe)
    else $error("serial output not enabled after select");
  chk_sdo_fs_on: assert property ($fell(frame_sync_n) && !cs_n |-> ##[1:6] sdo_oe)
    else $error("serial output not enabled after frame sync");
  chk_cs_sclk_low: assert property ($changed(cs_n) |-> !sclk)
    else $error("select moved while SCLK high");
  chk_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("SCLK high while idle");
  chk_out_plain_hold: assert property ($rose(sclk) && sdo_oe && !fs_mode_r
    |-> ##1 $stable(sdo_o) [*3])
    else $error("plain output moved near rising SCLK");
  chk_out_fs_hold: assert property ($fell(sclk) && sdo_oe && fs_mode_r
    |-> ##1 $stable(sdo_o) [*3])
    else $error("frame sync output moved near falling SCLK");
  chk_float_after_16: assert property (rise_cnt_r == 5'h10 && $fell(sclk) && !fs_mode_r
    |-> ##[1:6] !sdo_oe)
    else $error("serial output not floated after last bit");
  chk_frame_length: assert property ($rose(cs_n) |-> rise_cnt_r == 5'h10)
    else $error("frame did not carry sixteen clocks");
  chk_flag_fall_cs: assert property ($fell(flag_n) |-> cs_n)
    else $error("flag fell while selected");
endmodule : adcsp_properties
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench joining the host and converter ends over the serial link.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import adcsp_pkg::*;
  // ==========================================================================
  // Clock, reset, bus and user-side signals.
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] sample_value = 12'h9C5;
  logic [11:0] cfg_data;
  logic [3:0]  last_cmd;
  logic        cmd_valid, sampling, converting, analog_on, err;
  logic [31:0] rd;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          pulses = 0;
  adcsp_if adcsp_if_inst ();
  adcsp_host adcsp_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(adcsp_if_inst.host));
  adcsp_dev adcsp_dev_inst (.pclk(pclk), .presetn(presetn), .link(adcsp_if_inst.dev),
    .sample_value(sample_value), .cfg_data(cfg_data), .last_cmd(last_cmd),
    .cmd_valid(cmd_valid), .sampling(sampling), .converting(converting),
    .analog_on(analog_on));
  adcsp_properties adcsp_properties_inst (.pclk(pclk), .presetn(presetn),
    .cs_n(adcsp_if_inst.cs_n), .sclk(adcsp_if_inst.sclk),
    .frame_sync_n(adcsp_if_inst.frame_sync_n), .sdo_o(adcsp_if_inst.sdo_o),
    .sdo_oe(adcsp_if_inst.sdo_oe), .flag_n(adcsp_if_inst.flag_n));
  // ==========================================================================
  // Clock, hang guard and command pulse counter.
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cmd_valid === 1'b1) pulses <= pulses + 1;
    if (cycles == 8000) begin
      num_errors++;
      give_verdict();
    end
  end
  // ==========================================================================
  // Tasks for the verdict, comparisons and bus cycles.
  task automatic give_verdict();
    if (num_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic compare(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : compare
  // One APB transfer; request held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [11:0] addr, input logic [31:0] mask,
                       input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    compare(rd & mask, exp, "register read");
  endtask : rdchk
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge pclk);
  endtask : wait_cyc
  // Polls the busy bit; a bound keeps a stuck frame from hanging here.
  task automatic frame(input logic [31:0] tx, input logic [31:0] ctrl);
    int n;
    apb(1'b1, REG_TXDATA, tx);
    apb(1'b1, REG_CTRL, ctrl);
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (rd[ST_BUSY] !== 1'b0 && n < 100);
    compare({31'h0, rd[ST_BUSY]}, 32'h0, "busy");
    wait_cyc(4);
  endtask : frame
  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(REG_CTRL, 32'hF, 32'hC);
    rdchk(REG_STATUS, 32'h3, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    compare({31'h0, err}, 32'h1, "unmapped error");
    // Plain frame writing configuration with conversion mode 00.
    frame(32'hA5A3, 32'hD);
    compare(32'(last_cmd), 32'hA, "command");
    compare(32'(cfg_data), 32'h5A3, "config data");
    compare(32'(pulses), 32'h1, "command pulses");
    rdchk(REG_RXDATA, 32'hFFF0, 32'h9C50);
    // Frame sync timing with a short command; config must not change.
    sample_value <= 12'h36A;
    frame(32'h1FFF, 32'hF);
    compare(32'(last_cmd), 32'h1, "fs command");
    compare(32'(cfg_data), 32'h5A3, "config kept");
    rdchk(REG_RXDATA, 32'hFFF0, 32'h36A0);
    // Start pin sampling and conversion in mode 00.
    apb(1'b1, REG_CTRL, 32'h8);
    wait_cyc(8);
    compare({31'h0, sampling}, 32'h1, "sampling");
    apb(1'b1, REG_CTRL, 32'hC);
    wait_cyc(6);
    compare({31'h0, converting}, 32'h1, "converting");
    compare({31'h0, adcsp_if_inst.flag_n}, 32'h0, "end flag low");
    wait_cyc(40);
    compare({31'h0, converting}, 32'h0, "conversion done");
    compare({31'h0, adcsp_if_inst.flag_n}, 32'h1, "end flag high");
    // Mode 01: start pin lowered after the seventh SCLK waits for select to rise.
    frame(32'hA008, 32'hD);
    apb(1'b1, REG_CTRL, 32'hD);
    wait_cyc(50);
    apb(1'b1, REG_CTRL, 32'h8);
    wait_cyc(10);
    compare({31'h0, sampling}, 32'h0, "deferred sampling");
    frame(32'h1000, 32'h8);
    compare({31'h0, sampling}, 32'h1, "sampling after select");
    apb(1'b1, REG_CTRL, 32'hC);
    wait_cyc(40);
    compare({31'h0, adcsp_if_inst.flag_n}, 32'h0, "ready flag");
    frame(32'h1000, 32'hD);
    compare({31'h0, adcsp_if_inst.flag_n}, 32'h1, "ready flag cleared");
    // Power down and restart through a frame.
    apb(1'b1, REG_CTRL, 32'h4);
    wait_cyc(6);
    compare({31'h0, analog_on}, 32'h0, "powered down");
    apb(1'b1, REG_CTRL, 32'hC);
    frame(32'h1000, 32'hD);
    compare({31'h0, analog_on}, 32'h1, "restarted");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
